/* File: hdl/sui_pkg.sv */
// Shared constants for the script interrupt unit
package sui_pkg;

	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int SUI_ADDR_W = 16;
	localparam int SUI_NSRC = 11;
	localparam int SUI_NFLAG = 2;

	// ----------------------------------------------------------------
	// Opcodes handled by this unit
	// ----------------------------------------------------------------
	localparam logic [7:0] SUI_GET_AXIS_PARAM_OP = 8'h06;
	localparam logic [7:0] SUI_SET_GLOBAL_PARAM_OP = 8'h09;
	localparam logic [7:0] SUI_GET_GLOBAL_PARAM_OP = 8'h0a;
	localparam logic [7:0] SUI_IRQ_ENABLE_OP = 8'h19;
	localparam logic [7:0] SUI_IRQ_DISABLE_OP = 8'h1a;
	localparam logic [7:0] SUI_CALC_ACCU_XREG_OP = 8'h21;
	localparam logic [7:0] SUI_BIND_VECTOR_OP = 8'h25;
	localparam logic [7:0] SUI_IRQ_RETURN_OP = 8'h26;
	localparam logic [7:0] SUI_VAR_WITH_XREG_OP = 8'h2b;
	localparam logic [7:0] SUI_XREG_WITH_VAR_OP = 8'h2c;
	localparam logic [7:0] SUI_MOVE_TO_ACCU_POS_OP = 8'h2e;
	localparam logic [7:0] SUI_DECREMENT_BRANCH_OP = 8'h31;
	localparam logic [7:0] SUI_ROTATE_LEFT_ACCU_OP = 8'h32;
	localparam logic [7:0] SUI_ROTATE_RIGHT_ACCU_OP = 8'h33;

	// ----------------------------------------------------------------
	// Arithmetic operation selectors (type field)
	// ----------------------------------------------------------------
	localparam logic [7:0] SUI_CALC_ADD = 8'h00;
	localparam logic [7:0] SUI_CALC_SUB = 8'h01;
	localparam logic [7:0] SUI_CALC_AND = 8'h02;
	localparam logic [7:0] SUI_CALC_OR = 8'h03;
	localparam logic [7:0] SUI_CALC_XOR = 8'h04;
	localparam logic [7:0] SUI_CALC_LOAD = 8'h05;

	// ----------------------------------------------------------------
	// Interrupt numbers, source index order is ascending number
	// ----------------------------------------------------------------
	localparam logic [7:0] SUI_TIMER_ZERO_IRQ_CONST = 8'h00;
	localparam logic [7:0] SUI_GLOBAL_IRQ_CONST = 8'hff;
	localparam logic [7:0] SUI_IRQ_SETTINGS_BANK = 8'h03;
	localparam logic [7:0] SUI_SRC_NUM [SUI_NSRC] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h0f, 8'h15,
		8'h1b, 8'h1c, 8'h27, 8'h28, 8'h29};
	localparam int SUI_IDX_TARGET = 3;
	localparam int SUI_IDX_STALL = 4;
	localparam int SUI_IDX_DEVIATION = 5;
	localparam int SUI_IDX_LEFT = 6;
	localparam int SUI_IDX_RIGHT = 7;
	localparam int SUI_IDX_INPUT0 = 8;

	// ----------------------------------------------------------------
	// Timing and reset values
	// ----------------------------------------------------------------
	localparam int SUI_CLK_MHZ = 100;
	localparam int SUI_TICK_US = 1000;
	localparam int SUI_CYC_PER_TICK = SUI_TICK_US * SUI_CLK_MHZ;
	localparam logic [31:0] SUI_PERIOD_RST = 32'h0000_0000;
	localparam logic [31:0] SUI_ACCU_RST = 32'h0000_0000;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic {SUI_MAIN, SUI_HANDLER} sui_mode_e;

endpackage : sui_pkg

/* File: hdl/sui_timer_if.sv */
// Period and tick link between the interrupt core and one interval timer
`timescale 1ns/10ps
interface sui_timer_if;
	logic [31:0] period;
	logic tick;
	modport ctl (output period, input tick);
	modport tmr (input period, output tick);
endinterface : sui_timer_if

/* File: hdl/sui_interval_timer.sv */
// Millisecond interval timer raising one tick per elapsed period
`timescale 1ns/10ps
module sui_interval_timer #(
	parameter int CYC_PER_TICK = sui_pkg::SUI_CYC_PER_TICK
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Period in, tick out
	sui_timer_if.tmr tmr
);
	import sui_pkg::*;

	logic [31:0] preQ, preD;
	logic [31:0] msQ, msD;
	logic tickQ;
	wire logic msStep = (preQ >= 32'(CYC_PER_TICK - 1));
	wire logic expire = msStep && (msQ + 32'h1 >= tmr.period);
	wire logic running = (tmr.period != 32'h0);

	// Prescaler and period count; a zero period parks the timer
	assign preD = (!running || msStep) ? 32'h0 : preQ + 32'h1;
	assign msD = (!running || expire) ? 32'h0 : (msStep ? msQ + 32'h1 : msQ);

	// Counters
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			preQ <= 32'h0;
			msQ <= 32'h0;
			tickQ <= 1'b0;
		end
		else
		begin
			preQ <= preD;
			msQ <= msD;
			tickQ <= running && expire;
		end
	end

	assign tmr.tick = tickQ;

endmodule : sui_interval_timer

/* File: hdl/sui_script_irq.sv */
// Accumulator context, interrupt dispatch and return for the script interpreter
`timescale 1ns/10ps

module sui_script_irq #(
	parameter int CYC_PER_TICK = sui_pkg::SUI_CYC_PER_TICK
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Executed instruction from the interpreter
	input wire logic cmdValid,
	input wire logic cmdFromHost,
	input wire logic [7:0] cmdOpcode,
	input wire logic [7:0] cmdType,
	input wire logic [7:0] cmdBank,
	input wire logic [31:0] cmdValue,
	input wire logic [31:0] varRdData,
	// Value-reading result from the parameter side
	input wire logic readValid,
	input wire logic readFromHost,
	input wire logic [31:0] readData,
	// Program counter handshake
	input wire logic instrBoundary,
	input wire logic [sui_pkg::SUI_ADDR_W-1:0] pcNow,
	output logic pcLoad,
	output logic [sui_pkg::SUI_ADDR_W-1:0] pcTarget,
	output logic inHandler,
	// Event pins
	input wire logic targetReached,
	input wire logic stallDetect,
	input wire logic posDeviation,
	input wire logic leftStop,
	input wire logic rightStop,
	input wire logic [2:0] watchIn,
	// Context view
	output logic [31:0] accu,
	output logic [31:0] xreg,
	output logic [sui_pkg::SUI_NFLAG-1:0] flags,
	// Host reply
	output logic hostReplyValid,
	output logic [31:0] hostReplyData,
	// Variable write back
	output logic varWr,
	output logic [7:0] varWrIdx,
	output logic [31:0] varWrData,
	// Motion requests
	output logic moveValid,
	output logic [7:0] moveMode,
	output logic [31:0] moveTarget,
	output logic rotValid,
	output logic rotLeft,
	output logic [31:0] rotSpeed
);
	import sui_pkg::*;

	// ----------------------------------------------------------------
	// Arithmetic helper
	// ----------------------------------------------------------------
	function automatic logic [31:0] calc(input logic [7:0] op, input logic [31:0] a, input logic [31:0] b);
		case (op)
			SUI_CALC_ADD: calc = a + b;
			SUI_CALC_SUB: calc = a - b;
			SUI_CALC_AND: calc = a & b;
			SUI_CALC_OR: calc = a | b;
			SUI_CALC_XOR: calc = a ^ b;
			SUI_CALC_LOAD: calc = b;
			default: calc = a;
		endcase
	endfunction : calc

	// ----------------------------------------------------------------
	// Event pin synchronisers and edge detection
	// ----------------------------------------------------------------
	localparam int NPIN = 8;
	logic [NPIN-1:0] syncAQ, syncBQ, lastQ;
	logic [2:0] primeQ;
	wire logic [NPIN-1:0] pinsRaw = {watchIn, rightStop, leftStop, posDeviation, stallDetect, targetReached};

	// Two stages before any logic; a third stage holds the prior level
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			syncAQ <= '0;
			syncBQ <= '0;
			lastQ <= '0;
			primeQ <= '0;
		end
		else
		begin
			syncAQ <= pinsRaw;
			syncBQ <= syncAQ;
			lastQ <= syncBQ;
			primeQ <= {primeQ[1:0], 1'b1};
		end
	end

	// Motion events fire on rising edge, watched inputs on any change
	// Masked until the pipe refills after reset, so a pin already high raises nothing
	wire logic [4:0] riseEv = (syncBQ[4:0] & ~lastQ[4:0]) & {5{primeQ[2]}};
	wire logic [2:0] chgEv = (syncBQ[7:5] ^ lastQ[7:5]) & {3{primeQ[2]}};

	// ----------------------------------------------------------------
	// Interval timers, period set through bank 3
	// ----------------------------------------------------------------
	logic [31:0] periodQ [3];
	logic [2:0] timerTick;
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++)
		begin : g_tmr
			sui_timer_if tif ();
			assign tif.period = periodQ[gi];
			assign timerTick[gi] = tif.tick;
			sui_interval_timer #(.CYC_PER_TICK(CYC_PER_TICK)) u_tmr (.clk(clk), .rst(rst), .tmr(tif));
		end
	endgenerate

	// Source event vector in ascending interrupt number order
	wire logic [SUI_NSRC-1:0] srcEv = {chgEv, riseEv, timerTick};

	// ----------------------------------------------------------------
	// Instruction decode
	// ----------------------------------------------------------------
	wire logic progCmd = cmdValid && !cmdFromHost;
	wire logic isEnable = cmdValid && (cmdOpcode == SUI_IRQ_ENABLE_OP);
	wire logic isDisable = cmdValid && (cmdOpcode == SUI_IRQ_DISABLE_OP);
	wire logic isBind = cmdValid && (cmdOpcode == SUI_BIND_VECTOR_OP);
	wire logic isReturn = progCmd && (cmdOpcode == SUI_IRQ_RETURN_OP);
	wire logic isSetBank3 = cmdValid && (cmdOpcode == SUI_SET_GLOBAL_PARAM_OP) && (cmdBank == SUI_IRQ_SETTINGS_BANK);
	wire logic isCalcX = progCmd && (cmdOpcode == SUI_CALC_ACCU_XREG_OP);
	wire logic isVarX = progCmd && (cmdOpcode == SUI_VAR_WITH_XREG_OP);
	wire logic isXVar = progCmd && (cmdOpcode == SUI_XREG_WITH_VAR_OP);
	wire logic isDecBr = progCmd && (cmdOpcode == SUI_DECREMENT_BRANCH_OP);
	wire logic isMove = progCmd && (cmdOpcode == SUI_MOVE_TO_ACCU_POS_OP);
	wire logic isRotL = progCmd && (cmdOpcode == SUI_ROTATE_LEFT_ACCU_OP);
	wire logic isRotR = progCmd && (cmdOpcode == SUI_ROTATE_RIGHT_ACCU_OP);
	wire logic isGlobal = (cmdType == SUI_GLOBAL_IRQ_CONST);

	// Interrupt number to source one-hot
	logic [SUI_NSRC-1:0] numHit;
	always_comb
	begin
		for (int i = 0; i < SUI_NSRC; i++)
			numHit[i] = (cmdType == SUI_SRC_NUM[i]);
	end

	// ----------------------------------------------------------------
	// Interrupt state
	// ----------------------------------------------------------------
	sui_mode_e modeQ, modeD;
	logic [SUI_NSRC-1:0] pendQ, enQ, vecOkQ;
	logic [SUI_ADDR_W-1:0] vecQ [SUI_NSRC];
	logic globalEnQ;
	logic [31:0] accuQ, accuD, xregQ, xregD;
	logic [SUI_NFLAG-1:0] flagsQ, flagsD;
	logic [31:0] saveAccuQ, saveXQ;
	logic [SUI_NFLAG-1:0] saveFlagsQ;
	logic [SUI_ADDR_W-1:0] savePcQ;

	// Eligible sources and lowest-number pick
	wire logic [SUI_NSRC-1:0] ready = pendQ & enQ & vecOkQ;
	logic [SUI_NSRC-1:0] pick;
	logic [SUI_ADDR_W-1:0] pickVec;
	always_comb
	begin
		pick = '0;
		pickVec = '0;
		for (int i = SUI_NSRC - 1; i >= 0; i--)
		begin
			if (ready[i])
			begin
				pick = '0;
				pick[i] = 1'b1;
				pickVec = vecQ[i];
			end
		end
	end

	// Take only at a quiet boundary, outside any handler, with global enable
	// Held off while a pc load is pending, else the saved pc would be stale
	wire logic take = (modeQ == SUI_MAIN) && globalEnQ && (ready != '0) && instrBoundary
		&& !cmdValid && !pcLoad;

	// Mode sequencing
	always_comb
	begin
		modeD = modeQ;
		case (modeQ)
			SUI_MAIN: if (take) modeD = SUI_HANDLER;
			SUI_HANDLER: if (isReturn) modeD = SUI_MAIN;
			default: modeD = SUI_MAIN;
		endcase
	end

	// ----------------------------------------------------------------
	// Context next values
	// ----------------------------------------------------------------
	wire logic [31:0] varMinus = varRdData - 32'h1;
	wire logic progRead = readValid && !readFromHost;
	always_comb
	begin
		accuD = accuQ;
		xregD = xregQ;
		if (modeQ == SUI_HANDLER && isReturn)
		begin
			accuD = saveAccuQ;
			xregD = saveXQ;
		end
		else if (progRead)
			accuD = readData;
		else if (isCalcX && cmdType == SUI_CALC_LOAD)
			xregD = accuQ;
		else if (isCalcX)
			accuD = calc(cmdType, accuQ, xregQ);
		else if (isXVar)
			xregD = calc(cmdType, xregQ, varRdData);
	end

	// Flags track the last accumulator result: {negative, zero}
	always_comb
	begin
		flagsD = flagsQ;
		if (modeQ == SUI_HANDLER && isReturn)
			flagsD = saveFlagsQ;
		else if (accuD != accuQ || progRead || isCalcX)
			flagsD = {accuD[31], accuD == 32'h0};
	end

	// ----------------------------------------------------------------
	// Enables, vectors, settings and pending flags
	// ----------------------------------------------------------------
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			enQ <= '0;
			globalEnQ <= 1'b0;
			vecOkQ <= '0;
			pendQ <= '0;
			for (int i = 0; i < SUI_NSRC; i++)
				vecQ[i] <= '0;
			for (int i = 0; i < 3; i++)
				periodQ[i] <= SUI_PERIOD_RST;
		end
		else
		begin
			if (isEnable && isGlobal)
				globalEnQ <= 1'b1;
			else if (isDisable && isGlobal)
				globalEnQ <= 1'b0;
			if (isEnable)
				enQ <= enQ | numHit;
			else if (isDisable)
				enQ <= enQ & ~numHit;
			for (int i = 0; i < SUI_NSRC; i++)
			begin
				if (isBind && numHit[i])
				begin
					vecQ[i] <= cmdValue[SUI_ADDR_W-1:0];
					vecOkQ[i] <= 1'b1;
				end
			end
			for (int i = 0; i < 3; i++)
				if (isSetBank3 && numHit[i])
					periodQ[i] <= cmdValue;
			// New event beats the clear of the one being served
			pendQ <= (pendQ & ~(take ? pick : '0)) | srcEv;
		end
	end

	// ----------------------------------------------------------------
	// Context registers and save area
	// ----------------------------------------------------------------
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			modeQ <= SUI_MAIN;
			accuQ <= SUI_ACCU_RST;
			xregQ <= SUI_ACCU_RST;
			flagsQ <= '0;
			saveAccuQ <= SUI_ACCU_RST;
			saveXQ <= SUI_ACCU_RST;
			saveFlagsQ <= '0;
			savePcQ <= '0;
		end
		else
		begin
			modeQ <= modeD;
			accuQ <= accuD;
			xregQ <= xregD;
			flagsQ <= flagsD;
			if (take)
			begin
				saveAccuQ <= accuQ;
				saveXQ <= xregQ;
				saveFlagsQ <= flagsQ;
				savePcQ <= pcNow;
			end
		end
	end

	// ----------------------------------------------------------------
	// Program counter redirect, replies and side requests
	// ----------------------------------------------------------------
	wire logic decBrJump = isDecBr && (varMinus != 32'h0);
	wire logic retJump = isReturn && (modeQ == SUI_HANDLER);
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			pcLoad <= 1'b0;
			pcTarget <= '0;
			hostReplyValid <= 1'b0;
			hostReplyData <= '0;
			varWr <= 1'b0;
			varWrIdx <= '0;
			varWrData <= '0;
			moveValid <= 1'b0;
			moveMode <= '0;
			moveTarget <= '0;
			rotValid <= 1'b0;
			rotLeft <= 1'b0;
			rotSpeed <= '0;
		end
		else
		begin
			pcLoad <= take || retJump || decBrJump;
			pcTarget <= take ? pickVec : (retJump ? savePcQ : cmdValue[SUI_ADDR_W-1:0]);
			hostReplyValid <= readValid && readFromHost;
			hostReplyData <= readData;
			varWr <= isVarX || isDecBr;
			varWrIdx <= cmdValue[7:0];
			varWrData <= isDecBr ? varMinus : calc(cmdType, varRdData, xregQ);
			moveValid <= isMove;
			moveMode <= cmdType;
			moveTarget <= accuQ;
			rotValid <= isRotL || isRotR;
			rotLeft <= isRotL;
			rotSpeed <= accuQ;
		end
	end

	// Context view straight from the registers
	assign accu = accuQ;
	assign xreg = xregQ;
	assign flags = flagsQ;
	assign inHandler = (modeQ == SUI_HANDLER);

endmodule : sui_script_irq

/* File: tb/sui_prog_model.sv */
// Program side model: program counter and instruction boundary
`timescale 1ns/10ps
module sui_prog_model (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Program counter handshake
	input wire logic pcLoad,
	input wire logic [sui_pkg::SUI_ADDR_W-1:0] pcTarget,
	output logic instrBoundary,
	output logic [sui_pkg::SUI_ADDR_W-1:0] pcNow
);
	import sui_pkg::*;
	logic [1:0] phase_q;
	logic [SUI_ADDR_W-1:0] pc_q;
	// Boundary only half the time, so a take is sometimes held off
	assign instrBoundary = phase_q[1];
	assign pcNow = pc_q;
	// Pc moves only on loads, so flow never runs into a handler
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			phase_q <= 2'h0;
			pc_q <= 16'h0040;
		end
		else
		begin
			phase_q <= phase_q + 2'h1;
			if (pcLoad)
				pc_q <= pcTarget;
		end
	end
endmodule : sui_prog_model

/* File: tb/sui_script_irq_chk.sv */
// Port checks for the script interrupt unit
`timescale 1ns/10ps
module sui_script_irq_chk #(
	parameter int CYC_PER_TICK = sui_pkg::SUI_CYC_PER_TICK
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Requests
	input wire logic cmdValid,
	input wire logic cmdFromHost,
	input wire logic [7:0] cmdOpcode,
	input wire logic [31:0] varRdData,
	input wire logic readValid,
	input wire logic readFromHost,
	input wire logic [31:0] readData,
	// Answers
	input wire logic pcLoad,
	input wire logic inHandler,
	input wire logic [31:0] accu,
	input wire logic [31:0] xreg,
	input wire logic hostReplyValid,
	input wire logic [31:0] hostReplyData,
	input wire logic varWr,
	input wire logic [31:0] varWrData,
	input wire logic moveValid,
	input wire logic [31:0] moveTarget,
	input wire logic rotValid,
	input wire logic rotLeft,
	input wire logic [31:0] rotSpeed
);
	import sui_pkg::*;
	logic [31:0] savedAccu_q, savedX_q;
	wire logic progCmd;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// ----------------------------------------------------------------
	// Helper context copy
	// ----------------------------------------------------------------
	// Frozen while a handler runs, mirrors the saved context
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			savedAccu_q <= 32'h0;
			savedX_q <= 32'h0;
		end
		else if (!inHandler)
		begin
			savedAccu_q <= accu;
			savedX_q <= xreg;
		end
	end
	assign progCmd = cmdValid && !cmdFromHost;
	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	a_prog_read_accu: assert property (readValid && !readFromHost |=> accu == $past(readData))
		else $error("program read did not load accu");
	a_host_reply: assert property (readValid && readFromHost |=> hostReplyValid && hostReplyData == $past(readData))
		else $error("host read reply wrong");
	a_host_accu_kept: assert property (readValid && readFromHost && !cmdValid |=> $stable(accu))
		else $error("host read changed accu");
	a_move_accu_pos: assert property (progCmd && cmdOpcode == SUI_MOVE_TO_ACCU_POS_OP
		|=> moveValid && moveTarget == $past(accu)) else $error("move target wrong");
	a_rotate_dir_speed: assert property (progCmd && cmdOpcode[7:1] == 7'h19
		|=> rotValid && rotLeft != $past(cmdOpcode[0]) && rotSpeed == $past(accu)) else $error("rotate wrong");
	a_dec_branch_count: assert property (progCmd && cmdOpcode == SUI_DECREMENT_BRANCH_OP |=> varWr
		&& varWrData == $past(varRdData) - 32'h1 && pcLoad == ($past(varRdData) != 32'h1))
		else $error("decrement branch wrong");
	a_entry_load: assert property ($rose(inHandler) |-> pcLoad)
		else $error("handler entered without vector load");
	a_no_nesting: assert property (inHandler && !cmdValid |=> !pcLoad)
		else $error("diverted inside a handler");
	a_return_restore: assert property (progCmd && cmdOpcode == SUI_IRQ_RETURN_OP && inHandler |=> pcLoad
		&& !inHandler && accu == savedAccu_q && xreg == savedX_q) else $error("return context wrong");
endmodule : sui_script_irq_chk
bind sui_script_irq sui_script_irq_chk #(.CYC_PER_TICK(CYC_PER_TICK)) u_chk (.clk, .rst, .cmdValid, .cmdFromHost,
	.cmdOpcode, .varRdData, .readValid, .readFromHost, .readData, .pcLoad, .inHandler, .accu, .xreg, .hostReplyValid,
	.hostReplyData, .varWr, .varWrData, .moveValid, .moveTarget, .rotValid, .rotLeft, .rotSpeed);

/* File: tb/tb_top.sv */
// Self-checking bench for the script interrupt unit
`timescale 1ns/10ps
module tb_top;
	import sui_pkg::*;
	logic clk = 1'b0, rst = 1'b1, cmdValid = 1'b0, cmdFromHost = 1'b0, readValid = 1'b0, readFromHost = 1'b0;
	logic [7:0] cmdOpcode = 8'h00, cmdType = 8'h00, cmdBank = 8'h03, pin = 8'h00;
	logic [31:0] cmdValue = 32'h0, varRdData = 32'h0, readData = 32'h0;
	wire logic instrBoundary, pcLoad, inHandler, hostReplyValid, varWr, moveValid, rotValid, rotLeft;
	wire logic [15:0] pcNow, pcTarget;
	wire logic [31:0] accu, xreg, hostReplyData, varWrData, moveTarget, rotSpeed;
	wire logic [7:0] varWrIdx, moveMode;
	wire logic [1:0] flags;
	int failures = 0;
	int n_compared = 0;
	logic [7:0] nums [11] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h0f, 8'h15, 8'h1b, 8'h1c, 8'h27, 8'h28, 8'h29};
	// Clock at 100 MHz
	always #5 clk = ~clk;
	// Short tick keeps timer periods to a few cycles
	sui_script_irq #(.CYC_PER_TICK(8)) u_dut (.clk, .rst, .cmdValid, .cmdFromHost, .cmdOpcode, .cmdType, .cmdBank,
		.cmdValue, .varRdData, .readValid, .readFromHost, .readData, .instrBoundary, .pcNow, .pcLoad, .pcTarget,
		.inHandler, .targetReached(pin[0]), .stallDetect(pin[1]), .posDeviation(pin[2]), .leftStop(pin[3]),
		.rightStop(pin[4]), .watchIn(pin[7:5]), .accu, .xreg, .flags, .hostReplyValid, .hostReplyData, .varWr,
		.varWrIdx, .varWrData, .moveValid, .moveMode, .moveTarget, .rotValid, .rotLeft, .rotSpeed);
	sui_prog_model u_prog (.clk, .rst, .pcLoad, .pcTarget, .instrBoundary, .pcNow);
	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			failures++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wrap_up();
		$display("compared %0d, mismatched %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : wrap_up
	// One program instruction; returns in the cycle its answer stands
	task automatic cmd(input logic [7:0] op, input logic [7:0] typ, input logic [31:0] val, input logic [31:0] vr);
		@(negedge clk);
		cmdOpcode = op;
		cmdType = typ;
		cmdValue = val;
		varRdData = vr;
		cmdValid = 1'b1;
		@(negedge clk);
		cmdValid = 1'b0;
	endtask : cmd
	task automatic rd(input logic host, input logic [31:0] d);
		@(negedge clk);
		readFromHost = host;
		readData = d;
		readValid = 1'b1;
		@(negedge clk);
		readValid = 1'b0;
	endtask : rd
	// Vector zero means no take is expected in the window
	task automatic take(input logic [15:0] vec, input int lim);
		bit got;
		got = 1'b0;
		for (int i = 0; i < lim && !got; i++)
		begin
			@(negedge clk);
			got = (pcLoad === 1'b1);
		end
		if (vec == 16'h0)
			chk(32'(got), 32'h0);
		else if (!got)
		begin
			failures++;
			wrap_up();
		end
		else
			chk(32'({pcTarget, inHandler}), 32'({vec, 1'b1}));
	endtask : take
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_accu();
		rd(1'b0, 32'h0);
		chk(32'(flags), 32'h1);
		rd(1'b0, 32'h8000_0000);
		chk(32'(flags), 32'h2);
		rd(1'b0, 32'h1234_5678);
		chk(accu, 32'h1234_5678);
		rd(1'b1, 32'h0bad_cafe);
		chk(32'({hostReplyValid, hostReplyData}), 32'h0bad_cafe);
		chk(32'(hostReplyValid), 32'h1);
		chk(accu, 32'h1234_5678);
		cmd(SUI_CALC_ACCU_XREG_OP, SUI_CALC_LOAD, 32'h0, 32'h0);
		chk(xreg, 32'h1234_5678);
		cmd(SUI_MOVE_TO_ACCU_POS_OP, 8'h01, 32'h0, 32'h0);
		chk(moveTarget, 32'h1234_5678);
		chk(32'({moveValid, moveMode}), 32'h101);
		cmd(SUI_ROTATE_LEFT_ACCU_OP, 8'h00, 32'h0, 32'h0);
		chk(32'({rotValid, rotLeft}), 32'h3);
		cmd(SUI_ROTATE_RIGHT_ACCU_OP, 8'h00, 32'h0, 32'h0);
		chk(32'({rotValid, rotLeft}), 32'h2);
		chk(rotSpeed, 32'h1234_5678);
		$display("accumulator test done");
	endtask : t_accu
	task automatic t_calc();
		cmd(SUI_VAR_WITH_XREG_OP, SUI_CALC_ADD, 32'h7, 32'h10);
		chk({varWrIdx, varWrData[23:0]}, 32'h0734_5688);
		cmd(SUI_XREG_WITH_VAR_OP, SUI_CALC_SUB, 32'h7, 32'h8);
		chk(xreg, 32'h1234_5670);
		cmd(SUI_DECREMENT_BRANCH_OP, 8'h00, 32'h0203, 32'h5);
		chk({pcLoad, pcTarget, varWrData[14:0]}, {1'b1, 16'h0203, 15'h4});
		cmd(SUI_DECREMENT_BRANCH_OP, 8'h00, 32'h0305, 32'h1);
		chk(32'({pcLoad, varWr}), 32'h1);
		chk(varWrData, 32'h0);
		$display("calculation test done");
	endtask : t_calc
	task automatic t_sources();
		logic [15:0] pc;
		cmd(SUI_IRQ_ENABLE_OP, 8'hff, 32'h0, 32'h0);
		for (int k = 0; k < 11; k++)
		begin
			cmd(SUI_BIND_VECTOR_OP, nums[k], 32'h100 + 32'(k * 16), 32'h0);
			cmd(SUI_IRQ_ENABLE_OP, nums[k], 32'h0, 32'h0);
			rd(1'b0, 32'h0a00 + 32'(k));
			pc = pcNow;
			if (k < 3)
				cmd(SUI_SET_GLOBAL_PARAM_OP, 8'(k), 32'h1, 32'h0);
			else
				pin[k-3] = ~pin[k-3];
			take(16'h100 + 16'(k * 16), 100);
			rd(1'b0, 32'h0);
			if (k < 3)
				cmd(SUI_IRQ_DISABLE_OP, nums[k], 32'h0, 32'h0);
			else if (k < 8)
				pin[k-3] = 1'b0;
			cmd(SUI_IRQ_RETURN_OP, 8'h00, 32'h0, 32'h0);
			chk({pcLoad, inHandler, pcTarget}, {2'h2, pc});
			chk(accu, 32'h0a00 + 32'(k));
			chk(32'(flags), 32'h0);
		end
		$display("source test done");
	endtask : t_sources
	task automatic t_order();
		pin[4:3] = 2'h3;
		take(16'h160, 100);
		take(16'h0, 10);
		pin[4:3] = 2'h0;
		cmd(SUI_IRQ_RETURN_OP, 8'h00, 32'h0, 32'h0);
		take(16'h170, 100);
		cmd(SUI_IRQ_RETURN_OP, 8'h00, 32'h0, 32'h0);
		cmd(SUI_IRQ_DISABLE_OP, 8'hff, 32'h0, 32'h0);
		pin[0] = 1'b1;
		take(16'h0, 20);
		$display("order test done");
	endtask : t_order
	// Mid-run reset: outputs clear, vectors unbound, pins already high raise nothing
	task automatic t_reset();
		@(negedge clk);
		rst = 1'b1;
		@(negedge clk);
		chk(32'({pcLoad, inHandler, hostReplyValid, varWr, moveValid, rotValid, flags}), 32'h0);
		chk(accu | xreg, 32'h0);
		rst = 1'b0;
		pin[0] = 1'b0;
		cmd(SUI_IRQ_ENABLE_OP, 8'hff, 32'h0, 32'h0);
		cmd(SUI_BIND_VECTOR_OP, 8'h27, 32'h1f0, 32'h0);
		cmd(SUI_IRQ_ENABLE_OP, 8'h27, 32'h0, 32'h0);
		cmd(SUI_IRQ_ENABLE_OP, 8'h03, 32'h0, 32'h0);
		pin[0] = 1'b1;
		take(16'h0, 30);
		$display("reset test done");
	endtask : t_reset
	// Main sequence
	initial
	begin
		repeat (6) @(negedge clk);
		rst = 1'b0;
		t_accu();
		t_calc();
		t_sources();
		t_order();
		t_reset();
		wrap_up();
	end
endmodule : tb_top
